// ### design/trc_timer.sv
// 16-bit reload/capture timer with split 8-bit operation and Avalon-MM registers
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module trc_timer
  import trc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic count_pin_in,
  input wire logic [7:0] trigger_sources_in,
  input wire logic event_input_in,
  input wire logic s1_overflow_in,
  input wire logic t0_overflow_in,
  input wire logic t1_overflow_in,
  output logic irq_out,
  output logic overflow_event_out,
  output logic low_overflow_event_out
);

  trc_state_t st;
  trc_state_t next_st;

  logic split_enable;
  logic [2:0] mode_sel;
  logic capture_mode;
  logic tick12;
  logic pin_fall;
  logic main_tick;
  logic low_tick;
  logic external_trigger_input;
  logic edge_event_set;
  logic inc16;
  logic ovf16;
  logic inc_h;
  logic ovf_h;
  logic inc_l;
  logic ovf_l;
  logic wr_go;
  logic rd_go;

  assign split_enable = st.mode[TRC_MOD_SPLIT];
  assign mode_sel = {st.mode_ext[TRC_MX_MSH], st.control[TRC_CTL_CPRL],
                     st.mode[TRC_MOD_MSL]};
  assign capture_mode = (mode_sel == TRC_MODE_CAPTURE) || (mode_sel == TRC_MODE_CAPTURE_ZERO);
  assign tick12 = (st.div == TRC_DIV_LAST);
  // the pin is counted on its falling edge after the synchroniser
  assign pin_fall = st.pin_prev & ~st.pin_s2;
  assign external_trigger_input = st.trg_s2[st.mode_ext[2:0]];
  // trg_prev follows the selected source, so each transition is seen once
  assign edge_event_set = (st.trg_prev & ~external_trigger_input & st.control[TRC_CTL_FALL])
                        | (~st.trg_prev & external_trigger_input & st.mode[TRC_MOD_RISE]);

  // low byte clock, four choices
  always_comb begin
    case ({st.mode_ext[TRC_MX_LCS], st.mode[TRC_MOD_LX12]})
      TRC_LCK_DIV12: low_tick = tick12;
      TRC_LCK_SYS: low_tick = 1'b1;
      TRC_LCK_S1OVF: low_tick = s1_overflow_in;
      TRC_LCK_EVENT: low_tick = event_input_in;
      default: low_tick = 1'b0;
    endcase
  end

  assign inc_l = split_enable & st.mode[TRC_MOD_LRUN] & low_tick;
  assign ovf_l = inc_l & (st.count_low_byte == 8'hFF);

  // main clock, seven sources (code 6 gives no tick); code 3 chains to the low byte in split mode
  always_comb begin
    case ({st.mode_ext[TRC_MX_CKS], st.mode[TRC_MOD_X12], st.control[TRC_CTL_CSEL]})
      TRC_CK_DIV12: main_tick = tick12;
      TRC_CK_PIN: main_tick = pin_fall;
      TRC_CK_SYS: main_tick = 1'b1;
      TRC_CK_EVENT: main_tick = split_enable ? ovf_l : event_input_in;
      TRC_CK_S1OVF: main_tick = s1_overflow_in;
      TRC_CK_T0OVF: main_tick = t0_overflow_in;
      TRC_CK_T1OVF: main_tick = t1_overflow_in;
      default: main_tick = 1'b0;
    endcase
  end

  assign inc16 = ~split_enable & st.control[TRC_CTL_RUN] & main_tick;
  assign ovf16 = inc16 & ({st.count_high_byte, st.count_low_byte} == 16'hFFFF);
  assign inc_h = split_enable & st.control[TRC_CTL_RUN] & main_tick;
  assign ovf_h = inc_h & (st.count_high_byte == 8'hFF);

  // one wait cycle: data are registered on the first edge, handed over on the second
  assign wr_go = avs_write_in & st.ack;
  assign rd_go = (avs_read_in | avs_write_in) & ~st.ack;
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~st.ack;
  assign avs_readdata_out = st.rdata;
  assign overflow_event_out = st.ovf_pulse;
  assign low_overflow_event_out = st.low_ovf_pulse;

  // low flag counts only through its own enable; overflow through the ignore bit
  assign irq_out = (st.control[TRC_CTL_OVF] & ~st.mode_ext[TRC_MX_IGN])
                 | st.control[TRC_CTL_EXT]
                 | (st.low_byte_overflow_flag & st.low_overflow_irq_enable);

  always_comb begin
    logic [15:0] cnt16;
    logic [7:0] ctl_rd;
    logic wr_ok;
    cnt16 = {st.count_high_byte, st.count_low_byte};
    ctl_rd = 8'h00;
    wr_ok = wr_go & avs_byteenable_in[0];
    next_st = st;

    // synchronisers: first stage feeds only the second
    next_st.pin_s1 = count_pin_in;
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_prev = st.pin_s2;
    next_st.trg_s1 = trigger_sources_in;
    next_st.trg_s2 = st.trg_s1;
    next_st.trg_prev = external_trigger_input;
    next_st.div = tick12 ? TRC_RST_DIV : st.div + 4'h1;

    // counting, 16-bit
    if (!split_enable) begin
      if (capture_mode && edge_event_set) begin
        next_st.reload_capture_high = st.count_high_byte;
        next_st.reload_capture_low = st.count_low_byte;
      end
      if ((mode_sel == TRC_MODE_CAPTURE_ZERO) && edge_event_set) begin
        cnt16 = 16'h0000;
      end else if ((mode_sel == TRC_MODE_RELOAD_EXT) && edge_event_set) begin
        cnt16 = {st.reload_capture_high, st.reload_capture_low};
      end else if (ovf16) begin
        // capture modes wrap freely; reload modes reload
        cnt16 = capture_mode ? 16'h0000 :
                {st.reload_capture_high, st.reload_capture_low};
      end else if (inc16) begin
        cnt16 = cnt16 + 16'h0001;
      end
      next_st.count_high_byte = cnt16[15:8];
      next_st.count_low_byte = cnt16[7:0];
    end else begin
      // split: high byte carries mode behaviour, low byte free reload counter
      if (capture_mode && edge_event_set) begin
        next_st.reload_capture_high = st.count_high_byte;
      end
      if ((mode_sel == TRC_MODE_CAPTURE_ZERO) && edge_event_set) begin
        next_st.count_high_byte = 8'h00;
      end else if ((mode_sel == TRC_MODE_RELOAD_EXT) && edge_event_set) begin
        next_st.count_high_byte = st.reload_capture_high;
      end else if (ovf_h) begin
        next_st.count_high_byte = capture_mode ? 8'h00 : st.reload_capture_high;
      end else if (inc_h) begin
        next_st.count_high_byte = st.count_high_byte + 8'h01;
      end
      if (ovf_l) begin
        next_st.count_low_byte = st.reload_capture_low;
      end else if (inc_l) begin
        next_st.count_low_byte = st.count_low_byte + 8'h01;
      end
    end

    // exported events are registered, one cycle after the wrap
    next_st.ovf_pulse = split_enable ? ovf_l : ovf16;
    next_st.low_ovf_pulse = ovf_l;

    // register read, snapshot taken in the wait cycle
    ctl_rd = st.control;
    if (st.mode_ext[TRC_MX_VIEW]) begin
      ctl_rd[TRC_CTL_VIEW5] = st.low_byte_overflow_flag;
      ctl_rd[TRC_CTL_VIEW4] = st.low_overflow_irq_enable;
    end
    next_st.ack = rd_go;
    if (rd_go) begin
      case (avs_address_in)
        TRC_OFS_CONTROL: next_st.rdata = {24'h000000, ctl_rd};
        TRC_OFS_MODE: next_st.rdata = {24'h000000, st.mode};
        TRC_OFS_MODE_EXT: next_st.rdata = {24'h000000, st.mode_ext};
        TRC_OFS_COUNT_LOW: next_st.rdata = {24'h000000, st.count_low_byte};
        TRC_OFS_COUNT_HIGH: next_st.rdata = {24'h000000, st.count_high_byte};
        TRC_OFS_RELOAD_LOW: next_st.rdata = {24'h000000, st.reload_capture_low};
        TRC_OFS_RELOAD_HIGH: next_st.rdata = {24'h000000, st.reload_capture_high};
        default: next_st.rdata = 32'h00000000;
      endcase
    end

    // register write; count writes beat counting, hardware capture beats reload writes
    if (wr_ok) begin
      case (avs_address_in)
        TRC_OFS_CONTROL: begin
          next_st.control[7:6] = avs_writedata_in[7:6];
          next_st.control[3:0] = avs_writedata_in[3:0];
          if (st.mode_ext[TRC_MX_VIEW]) begin
            next_st.low_byte_overflow_flag = avs_writedata_in[TRC_CTL_VIEW5];
            next_st.low_overflow_irq_enable = avs_writedata_in[TRC_CTL_VIEW4];
          end else begin
            next_st.control[5:4] = avs_writedata_in[5:4];
          end
        end
        TRC_OFS_MODE: next_st.mode = avs_writedata_in[7:0];
        TRC_OFS_MODE_EXT: next_st.mode_ext = avs_writedata_in[7:0];
        TRC_OFS_COUNT_LOW: next_st.count_low_byte = avs_writedata_in[7:0];
        TRC_OFS_COUNT_HIGH: next_st.count_high_byte = avs_writedata_in[7:0];
        TRC_OFS_RELOAD_LOW: begin
          if (!(capture_mode && edge_event_set && !split_enable)) begin
            next_st.reload_capture_low = avs_writedata_in[7:0];
          end
        end
        TRC_OFS_RELOAD_HIGH: begin
          if (!(capture_mode && edge_event_set)) begin
            next_st.reload_capture_high = avs_writedata_in[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    // hardware sets after the write so a same-cycle set is never lost
    if (ovf16 || ovf_h) begin
      next_st.control[TRC_CTL_OVF] = 1'b1;
    end
    if (edge_event_set) begin
      next_st.control[TRC_CTL_EXT] = 1'b1;
    end
    if (ovf_l) begin
      next_st.low_byte_overflow_flag = 1'b1;
    end
    if (ovf_h && st.mode[TRC_MOD_LRUN] && st.mode[TRC_MOD_LCLR]) begin
      next_st.mode[TRC_MOD_LRUN] = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  ovf_flag_set_a: assert property (ovf16 |=> st.control[TRC_CTL_OVF])
    else $error("overflow did not set overflow flag");

  ext_flag_set_a: assert property (edge_event_set |=> st.control[TRC_CTL_EXT])
    else $error("trigger edge did not set external event flag");

  edge_once_a: assert property (edge_event_set |=> !edge_event_set)
    else $error("one trigger transition flagged twice");

  reload_value_a: assert property (!split_enable && mode_sel == TRC_MODE_RELOAD_EXT
      && ovf16 && !edge_event_set && !avs_write_in
      |=> {st.count_high_byte, st.count_low_byte}
          == $past({st.reload_capture_high, st.reload_capture_low}))
    else $error("overflow in mode 1 did not reload count");

  capture_copy_a: assert property (!split_enable && mode_sel == TRC_MODE_CAPTURE
      && edge_event_set && !avs_write_in
      |=> {st.reload_capture_high, st.reload_capture_low}
          == $past({st.count_high_byte, st.count_low_byte}))
    else $error("capture edge did not copy count");

  capture_zero_a: assert property (!split_enable && mode_sel == TRC_MODE_CAPTURE_ZERO
      && edge_event_set && !avs_write_in
      |=> {st.count_high_byte, st.count_low_byte} == 16'h0000)
    else $error("mode 3 edge did not zero count");

  irq_ext_a: assert property (st.control[TRC_CTL_EXT] |-> irq_out)
    else $error("external event flag without interrupt request");

  irq_ignore_a: assert property (!st.control[TRC_CTL_EXT] && !st.low_byte_overflow_flag
      && st.mode_ext[TRC_MX_IGN] |-> !irq_out)
    else $error("ignored overflow raised interrupt");

  low_autoclear_a: assert property (ovf_h && st.mode[TRC_MOD_LCLR] && !avs_write_in
      |=> !st.mode[TRC_MOD_LRUN])
    else $error("high overflow did not stop low counter");

  low_flag_set_a: assert property (ovf_l |=> st.low_byte_overflow_flag)
    else $error("low wrap did not set low flag");

  split_export_a: assert property (split_enable && ovf_l |=> overflow_event_out)
    else $error("split export is not low overflow");

  export_pulse_a: assert property (overflow_event_out |->
      $past(split_enable ? ovf_l : ovf16))
    else $error("exported overflow without a wrap one cycle before");

  flags_hold_a: assert property (split_enable && st.control[TRC_CTL_OVF]
      && !avs_write_in |=> st.control[TRC_CTL_OVF])
    else $error("split overflow flag cleared by hardware");

  wait_one_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out)
    else $error("bus answer not within one wait cycle");

  edge_reload_a: assert property (!split_enable && mode_sel == TRC_MODE_RELOAD_EXT
      && edge_event_set && !avs_write_in
      |=> {st.count_high_byte, st.count_low_byte}
          == $past({st.reload_capture_high, st.reload_capture_low}))
    else $error("mode 1 trigger edge did not reload count");

  capture_wrap_a: assert property (!split_enable && capture_mode && ovf16
      && !edge_event_set && !avs_write_in
      |=> {st.count_high_byte, st.count_low_byte} == 16'h0000)
    else $error("capture mode overflow did not wrap to zero");

  run_stop_a: assert property (!split_enable && !st.control[TRC_CTL_RUN]
      && !edge_event_set && !avs_write_in
      |=> $stable({st.count_high_byte, st.count_low_byte}))
    else $error("stopped counter moved");

  high_reload_a: assert property (split_enable && ovf_h && !capture_mode
      && !edge_event_set && !avs_write_in
      |=> st.count_high_byte == $past(st.reload_capture_high))
    else $error("split high byte did not reload");

  low_reload_a: assert property (ovf_l && !avs_write_in
      |=> st.count_low_byte == $past(st.reload_capture_low))
    else $error("low byte did not reload");

  low_stop_a: assert property (split_enable && !st.mode[TRC_MOD_LRUN] && !avs_write_in
      |=> $stable(st.count_low_byte))
    else $error("stopped low byte moved");

  low_hold_a: assert property (split_enable && st.low_byte_overflow_flag
      && !avs_write_in |=> st.low_byte_overflow_flag)
    else $error("split low flag cleared by hardware");

  irq_low_a: assert property (st.low_byte_overflow_flag && st.low_overflow_irq_enable
      |-> irq_out)
    else $error("enabled low flag without interrupt request");

  low_event_a: assert property (ovf_l |=> low_overflow_event_out)
    else $error("low wrap not exported");

  export16_a: assert property (!split_enable && ovf16 |=> overflow_event_out)
    else $error("16-bit overflow not exported");

  cover_ovf16_c: cover property (ovf16 ##1 overflow_event_out);
  cover_capture_c: cover property (capture_mode && edge_event_set);
  cover_split_low_c: cover property (split_enable && ovf_l);
  cover_autoclear_c: cover property (ovf_h && st.mode[TRC_MOD_LCLR] && st.mode[TRC_MOD_LRUN]);
  cover_edge_reload_c: cover property (!split_enable && mode_sel == TRC_MODE_RELOAD_EXT
      && edge_event_set);

endmodule : trc_timer

`default_nettype wire

// ### design/trc_pkg.sv
// constants and state layout shared by the reload/capture timer
package trc_pkg;

  // register byte offsets, one aligned 32-bit word each, data in bits 7:0
  localparam logic [4:0] TRC_OFS_CONTROL = 5'h00;
  localparam logic [4:0] TRC_OFS_MODE = 5'h04;
  localparam logic [4:0] TRC_OFS_MODE_EXT = 5'h08;
  localparam logic [4:0] TRC_OFS_COUNT_LOW = 5'h0C;
  localparam logic [4:0] TRC_OFS_COUNT_HIGH = 5'h10;
  localparam logic [4:0] TRC_OFS_RELOAD_LOW = 5'h14;
  localparam logic [4:0] TRC_OFS_RELOAD_HIGH = 5'h18;

  // control register field positions
  localparam int TRC_CTL_OVF = 7;
  localparam int TRC_CTL_EXT = 6;
  localparam int TRC_CTL_VIEW5 = 5;
  localparam int TRC_CTL_VIEW4 = 4;
  localparam int TRC_CTL_FALL = 3;
  localparam int TRC_CTL_RUN = 2;
  localparam int TRC_CTL_CSEL = 1;
  localparam int TRC_CTL_CPRL = 0;

  // mode register field positions
  localparam int TRC_MOD_SPLIT = 7;
  localparam int TRC_MOD_LX12 = 6;
  localparam int TRC_MOD_RISE = 5;
  localparam int TRC_MOD_X12 = 4;
  localparam int TRC_MOD_LRUN = 3;
  localparam int TRC_MOD_LCLR = 2;
  localparam int TRC_MOD_CKOE = 1;
  localparam int TRC_MOD_MSL = 0;

  // extended mode register field positions
  localparam int TRC_MX_LCS = 7;
  localparam int TRC_MX_IGN = 6;
  localparam int TRC_MX_VIEW = 5;
  localparam int TRC_MX_CKS = 4;
  localparam int TRC_MX_MSH = 3;

  // reset values
  localparam logic [7:0] TRC_RST_BYTE = 8'h00;
  localparam logic [3:0] TRC_RST_DIV = 4'h0;

  // system clock divided by twelve
  localparam logic [3:0] TRC_DIV_LAST = 4'hB;

  // mode encodings, ordered high, middle, low
  localparam logic [2:0] TRC_MODE_RELOAD = 3'h0;
  localparam logic [2:0] TRC_MODE_RELOAD_EXT = 3'h1;
  localparam logic [2:0] TRC_MODE_CAPTURE = 3'h2;
  localparam logic [2:0] TRC_MODE_CAPTURE_ZERO = 3'h3;

  // main clock source codes {cks, x12, counter_select}
  localparam logic [2:0] TRC_CK_DIV12 = 3'h0;
  localparam logic [2:0] TRC_CK_PIN = 3'h1;
  localparam logic [2:0] TRC_CK_SYS = 3'h2;
  localparam logic [2:0] TRC_CK_EVENT = 3'h3;
  localparam logic [2:0] TRC_CK_S1OVF = 3'h4;
  localparam logic [2:0] TRC_CK_T0OVF = 3'h5;
  localparam logic [2:0] TRC_CK_T1OVF = 3'h7;

  // low byte clock source codes {low_cs, low_x12}
  localparam logic [1:0] TRC_LCK_DIV12 = 2'h0;
  localparam logic [1:0] TRC_LCK_SYS = 2'h1;
  localparam logic [1:0] TRC_LCK_S1OVF = 2'h2;
  localparam logic [1:0] TRC_LCK_EVENT = 2'h3;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] mode;
    logic [7:0] mode_ext;
    logic low_byte_overflow_flag;
    logic low_overflow_irq_enable;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] reload_capture_low;
    logic [7:0] reload_capture_high;
    logic [3:0] div;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic [7:0] trg_s1;
    logic [7:0] trg_s2;
    logic trg_prev;
    logic ack;
    logic [31:0] rdata;
    logic ovf_pulse;
    logic low_ovf_pulse;
  } trc_state_t;

endpackage : trc_pkg

// ### tb/trc_periph_model.sv
// behavioural model of the on-chip peripherals that send event and overflow strobes
`timescale 1ns/1ps
`default_nettype none

module trc_periph_model #(
  parameter int GAP = 3
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic [1:0] kind_in,
  input wire logic [3:0] count_in,
  output logic busy_out,
  output logic [3:0] strobe_out
);
  logic [3:0] left;
  logic [1:0] kind;
  int wait_n;

  // strobes stay one cycle wide and spaced, so no two merge into one count
  always_ff @(posedge clk_in) begin
    strobe_out <= 4'h0;
    if (rst_in) begin
      left <= 4'h0;
      wait_n <= 0;
      busy_out <= 1'h0;
    end else if (go_in && !busy_out) begin
      left <= count_in;
      kind <= kind_in;
      wait_n <= GAP;
      busy_out <= (count_in != 4'h0);
    end else if (busy_out) begin
      if (wait_n != 0) begin
        wait_n <= wait_n - 1;
      end else begin
        strobe_out[kind] <= 1'h1;
        left <= left - 4'h1;
        wait_n <= GAP;
        busy_out <= (left != 4'h1);
      end
    end
  end
endmodule : trc_periph_model

`default_nettype wire

// ### tb/tb_trc_timer.sv
// self-checking bench for the reload/capture timer
`timescale 1ns/1ps
`default_nettype none

module tb_trc_timer
  import trc_pkg::*;
;
  typedef struct packed {
    logic [4:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } trc_row_t;

  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic [4:0] adr = 5'h00;
  logic rd_en = 1'h0;
  logic wr_en = 1'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wait_req, irq, ovf_ev, low_ev, busy;
  logic go = 1'h0;
  logic [3:0] cnt = 4'h0;
  logic [1:0] knd = 2'h0;
  logic pin = 1'h1;
  logic [7:0] src = 8'hFF;
  logic [3:0] strb;
  logic [7:0] q, h;
  int miscompares = 0;
  int n_compared = 0;
  int ovf_seen, low_seen;
  trc_row_t rows [8];
  logic [15:0] exp_cnt [3];
  logic [15:0] exp_rc [3];

  always #4 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    if (ovf_ev === 1'h1) ovf_seen++;
    if (low_ev === 1'h1) low_seen++;
  end

  trc_timer u_trc_timer (
    .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd_en),
    .avs_write_in(wr_en), .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_req), .count_pin_in(pin),
    .trigger_sources_in(src), .event_input_in(strb[0]), .s1_overflow_in(strb[1]),
    .t0_overflow_in(strb[2]), .t1_overflow_in(strb[3]), .irq_out(irq),
    .overflow_event_out(ovf_ev), .low_overflow_event_out(low_ev)
  );

  trc_periph_model u_trc_periph_model (
    .clk_in(clk_in), .rst_in(rst_in), .go_in(go), .kind_in(knd), .count_in(cnt),
    .busy_out(busy), .strobe_out(strb)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      miscompares++;
    end
  endtask : chk

  task automatic print_verdict();
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_in);
    adr <= a;
    wr_en <= w;
    rd_en <= ~w;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (wait_req !== 1'h0 && n < 50);
    r = rdat[7:0];
    rd_en <= 1'h0;
    wr_en <= 1'h0;
    if (wait_req !== 1'h0) begin
      miscompares++;
      print_verdict();
    end
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'h1, a, d, r);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] r);
    bus(1'h0, a, 8'h00, r);
  endtask : rd

  // mode registers first so the run bit lands on a finished setup
  task automatic cfg(input logic [7:0] mx, input logic [7:0] md, input logic [7:0] ct);
    wr(TRC_OFS_MODE_EXT, mx);
    wr(TRC_OFS_MODE, md);
    wr(TRC_OFS_CONTROL, ct);
  endtask : cfg

  // two sync stages, edge register, flag: six cycles leave margin
  task automatic settle();
    repeat (6) @(posedge clk_in);
  endtask : settle

  task automatic pulses(input logic [3:0] n);
    int t;
    t = 0;
    @(posedge clk_in);
    go <= 1'h1;
    cnt <= n;
    @(posedge clk_in);
    go <= 1'h0;
    do begin
      @(posedge clk_in);
      t++;
    end while (busy !== 1'h0 && t < 200);
    if (busy !== 1'h0) begin
      miscompares++;
      print_verdict();
    end
    settle();
  endtask : pulses

  initial begin
    rows = '{'{TRC_OFS_COUNT_LOW, 8'hA5, 8'hA5}, '{TRC_OFS_COUNT_HIGH, 8'h5A, 8'h5A},
             '{TRC_OFS_RELOAD_LOW, 8'hC3, 8'hC3}, '{TRC_OFS_RELOAD_HIGH, 8'h3C, 8'h3C},
             '{TRC_OFS_MODE, 8'h02, 8'h02}, '{TRC_OFS_MODE_EXT, 8'h07, 8'h07},
             '{TRC_OFS_CONTROL, 8'h30, 8'h30}, '{5'h1C, 8'hFF, 8'h00}};
    exp_cnt = '{16'h1111, 16'h5678, 16'h0000};
    exp_rc = '{16'h1111, 16'h5678, 16'h5678};
    repeat (20) @(posedge clk_in);
    rst_in <= 1'h0;
    foreach (rows[i]) begin
      rd(rows[i].a, q);
      chk(q, 8'h00);
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, q);
      chk(q, rows[i].e);
    end
    // two event counts from FFFE: one to FFFF, one to wrap
    for (int m = 0; m < 3; m++) begin
      wr(TRC_OFS_CONTROL, 8'h00);
      wr(TRC_OFS_RELOAD_LOW, 8'h34);
      wr(TRC_OFS_RELOAD_HIGH, 8'h12);
      wr(TRC_OFS_COUNT_LOW, 8'hFE);
      wr(TRC_OFS_COUNT_HIGH, 8'hFF);
      ovf_seen = 0;
      cfg(8'h00, 8'h10 | 8'(m == 1), 8'h06 | 8'(m == 2));
      pulses(4'h2);
      rd(TRC_OFS_COUNT_LOW, q);
      rd(TRC_OFS_COUNT_HIGH, h);
      chk({h, q}, (m < 2) ? 16'h1234 : 16'h0000);
      rd(TRC_OFS_CONTROL, q);
      chk(q, 8'h86 | 8'(m == 2));
      chk(16'(ovf_seen), 16'h0001);
      @(negedge clk_in);
      chk(irq, 1'h1);
      wr(TRC_OFS_MODE_EXT, 8'h40);
      @(negedge clk_in);
      chk(irq, 1'h0);
      wr(TRC_OFS_CONTROL, 8'h00);
    end
    for (int k = 0; k < 8; k++) begin
      cfg(8'(k), 8'h00, 8'h08);
      src[k] <= 1'h0;
      settle();
      rd(TRC_OFS_CONTROL, q);
      chk(q, 8'h48);
      @(negedge clk_in);
      chk(irq, 1'h1);
      wr(TRC_OFS_CONTROL, 8'h08);
      src[k] <= 1'h1;
      settle();
      rd(TRC_OFS_CONTROL, q);
      chk(q, 8'h08);
    end
    cfg(8'h07, 8'h20, 8'h00);
    src[7] <= 1'h0;
    settle();
    rd(TRC_OFS_CONTROL, q);
    chk(q, 8'h00);
    src[7] <= 1'h1;
    settle();
    rd(TRC_OFS_CONTROL, q);
    chk(q, 8'h40);
    // no counts arrive here, so only the edge moves the count
    for (int m = 1; m < 4; m++) begin
      wr(TRC_OFS_CONTROL, 8'h00);
      wr(TRC_OFS_COUNT_LOW, 8'h78);
      wr(TRC_OFS_COUNT_HIGH, 8'h56);
      wr(TRC_OFS_RELOAD_LOW, 8'h11);
      wr(TRC_OFS_RELOAD_HIGH, 8'h11);
      cfg(8'h00, 8'h10 | 8'(m[0]), 8'h0E | 8'(m[1]));
      src[0] <= 1'h0;
      settle();
      rd(TRC_OFS_COUNT_LOW, q);
      rd(TRC_OFS_COUNT_HIGH, h);
      chk({h, q}, exp_cnt[m-1]);
      rd(TRC_OFS_RELOAD_LOW, q);
      rd(TRC_OFS_RELOAD_HIGH, h);
      chk({h, q}, exp_rc[m-1]);
      src[0] <= 1'h1;
      settle();
    end
    wr(TRC_OFS_CONTROL, 8'h00);
    wr(TRC_OFS_RELOAD_LOW, 8'h80);
    wr(TRC_OFS_RELOAD_HIGH, 8'h40);
    wr(TRC_OFS_COUNT_LOW, 8'hFF);
    wr(TRC_OFS_COUNT_HIGH, 8'hFF);
    ovf_seen = 0;
    low_seen = 0;
    cfg(8'hA0, 8'hDC, 8'h16);
    pulses(4'h1);
    rd(TRC_OFS_COUNT_LOW, q);
    chk(q, 8'h80);
    rd(TRC_OFS_COUNT_HIGH, q);
    chk(q, 8'h40);
    rd(TRC_OFS_MODE, q);
    chk(q, 8'hD4);
    rd(TRC_OFS_CONTROL, q);
    chk(q, 8'hB6);
    chk(16'(ovf_seen), 16'h0001);
    chk(16'(low_seen), 16'h0001);
    @(negedge clk_in);
    chk(irq, 1'h1);
    pulses(4'h1);
    rd(TRC_OFS_COUNT_LOW, q);
    chk(q, 8'h80);
    rd(TRC_OFS_CONTROL, q);
    chk(q, 8'hB6);
    wr(TRC_OFS_CONTROL, 8'h16);
    @(negedge clk_in);
    chk(irq, 1'h0);
    @(posedge clk_in);
    rst_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'h0;
    rd(TRC_OFS_MODE, q);
    chk(q, 8'h00);
    chk({irq, ovf_ev, low_ev}, 3'h0);
    // on-chip overflow strobes as clocks: codes 4, 5 and 7
    for (int c = 1; c < 4; c++) begin
      wr(TRC_OFS_COUNT_LOW, 8'h00);
      knd <= 2'(c);
      cfg(8'h10, (c == 3) ? 8'h10 : 8'h00, (c > 1) ? 8'h06 : 8'h04);
      pulses(4'h3);
      rd(TRC_OFS_COUNT_LOW, q);
      chk(q, 8'h03);
      wr(TRC_OFS_CONTROL, 8'h00);
    end
    // count pin, taken on its falling edge behind the synchroniser
    wr(TRC_OFS_COUNT_LOW, 8'h00);
    cfg(8'h00, 8'h00, 8'h06);
    repeat (2) begin
      pin <= 1'h0;
      settle();
      pin <= 1'h1;
      settle();
    end
    rd(TRC_OFS_COUNT_LOW, q);
    chk(q, 8'h02);
    print_verdict();
  end
endmodule : tb_trc_timer

`default_nettype wire
